/* File: bench/fic_checker.sv */
// Port checker for the conversion decoder.
// Assumes it is bound onto the decoder top module.
`timescale 1ns/100ps
module fic_checker #(parameter [2:0] COPROC_SEL = 3'h0) (
	// Watched ports
	input wire i_clk,
	input wire i_sys_rst,
	input wire i_instr_valid,
	input wire [31:0] i_instr,
	input wire o_instr_ready,
	input wire i_data_valid,
	input wire o_data_ready,
	input wire o_busy,
	input wire o_done,
	input wire o_illegal
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	wire take = i_instr_valid && o_instr_ready;
	wire mine = take && i_instr[31:29] == COPROC_SEL;
	wire shrt = mine && i_instr[24:21] == 4'h6 && i_instr[15:0] == 16'h1F00;
	foreign_ignored_a: assert property (take && !mine |=> !o_busy && !o_illegal)
		else $error("foreign word acted on");
	short_latency_a: assert property (shrt && i_instr[20:17] != 4'hF |=> o_busy ##1 o_busy ##1 o_done)
		else $error("short form latency wrong");
	c_ct_refused_a: assert property (shrt && i_instr[20:17] == 4'hF |=> o_illegal)
		else $error("C or CT destination accepted");
	load_latency_a: assert property (i_data_valid && o_data_ready ##1 !o_data_ready
		|-> ##1 !o_done ##1 o_done)
		else $error("load form latency wrong");
	done_pulse_a: assert property (o_done |-> !o_busy && o_instr_ready ##1 !o_done)
		else $error("done not a single pulse");
	illegal_pulse_a: assert property (o_illegal |=> !o_illegal && !o_done)
		else $error("illegal not a single pulse");
	data_in_busy_a: assert property (o_data_ready |-> o_busy && !o_instr_ready)
		else $error("operand wait outside an instruction");
	busy_ends_a: assert property ($fell(o_busy) |-> o_done || $past(o_illegal))
		else $error("busy ended without done");
	cover property (o_done);
	cover property (o_illegal);
	cover property (i_data_valid && o_data_ready);
endmodule // fic_checker

bind float_int_convert_ops fic_checker #(.COPROC_SEL(COPROC_SEL)) fic_checker_inst (
	.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
	.o_instr_ready(o_instr_ready), .i_data_valid(i_data_valid), .o_data_ready(o_data_ready),
	.o_busy(o_busy), .o_done(o_done), .o_illegal(o_illegal));

/* File: bench/float_int_convert_ops_tb.sv */
// Random and corner stimulus for the conversion decoder.
// Assumes the host model feeds operand words.
`timescale 1ns/100ps
module float_int_convert_ops_tb;
	reg i_clk, i_sys_rst, ivalid, slow;
	reg [31:0] instr, word, k, f;
	reg [1:0] mode;
	reg [4:0] rd_addr, dst;
	reg [3:0] src;
	reg [2:0] sel;
	reg [15:0] seed;
	reg [9:0] a;
	integer i, errors, n_compared, cyc;
	wire o_instr_ready, dvalid, o_data_ready, o_busy, o_done, o_illegal;
	wire [31:0] ddata;
	wire [63:0] o_rd_data;
	float_int_convert_ops float_int_convert_ops_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_instr_valid(ivalid), .i_instr(instr), .o_instr_ready(o_instr_ready),
		.i_data_valid(dvalid), .i_data(ddata), .o_data_ready(o_data_ready), .i_rd_addr(rd_addr),
		.o_rd_data(o_rd_data), .o_busy(o_busy), .o_done(o_done), .o_illegal(o_illegal));
	host_model host_model_inst (.i_clk(i_clk), .i_mode(mode), .i_word(word), .i_slow(slow),
		.i_ready(o_data_ready), .o_valid(dvalid), .o_data(ddata));
	// ----------------------------------------
	// Expectations and helpers
	// ----------------------------------------
	function [15:0] lfsr(input [15:0] s);
		lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// Rounds the exact double down to single, nearest even
	function [63:0] i2s(input [31:0] v);
		reg [63:0] d;
		reg [10:0] e;
		begin
			d = $realtobits($itor($signed(v)));
			e = d[62:52] - 11'h380;
			if (v == 32'h0)
				i2s = 64'h0;
			else
				i2s = {32'h0, d[63], e[7:0], d[51:29]} + {63'h0, d[28] & (d[29] | (|d[27:0]))};
		end
	endfunction
	function [63:0] i2d(input [31:0] v);
		i2d = $realtobits($itor($signed(v)));
	endfunction
	// Saturating, NaN goes positive
	function [63:0] f2i(input [31:0] v);
		reg [63:0] d;
		begin
			d = {v[31], {3'h0, v[30:23]} + 11'h380, v[22:0], 29'h0};
			if (v[30:23] == 8'hFF && v[22:0] != 23'h0)
				f2i = 64'h7FFFFFFF;
			else if (v[30:23] >= 8'h9E)
				f2i = v[31] ? 64'h80000000 : 64'h7FFFFFFF;
			else
				f2i = {32'h0, $rtoi($bitstoreal(d))};
		end
	endfunction
	task chk(input [63:0] got, input [63:0] e);
		begin
			n_compared = n_compared + 1;
			if (got !== e) begin
				errors = errors + 1;
				$display("unexpected at %0t: got %h exp %h", $time, got, e);
			end
		end
	endtask
	task run(input [3:0] opc, input [15:0] sub, input [1:0] md, input [31:0] w, input [1:0] e);
		integer t;
		begin
			@(posedge i_clk);
			mode <= md;
			word <= w;
			instr <= {sel, src, opc, dst, sub};
			ivalid <= 1'b1;
			@(posedge i_clk);
			ivalid <= 1'b0;
			t = 0;
			do begin
				@(negedge i_clk);
				t = t + 1;
			end while (t < 20 && !(o_done | o_illegal));
			chk({o_done, o_illegal}, e);
		end
	endtask
	task rd(input [4:0] ad, input [63:0] e);
		begin
			@(posedge i_clk) rd_addr <= ad;
			@(posedge i_clk);
			@(negedge i_clk) chk(o_rd_data, e);
		end
	endtask
	task summarize;
		begin
			$display("compared %0d errors %0d", n_compared, errors);
			if (errors == 0 && n_compared > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end
	// Hang guard, tests need a few thousand cycles
	always @(posedge i_clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			errors = errors + 1;
			summarize;
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{ivalid, slow, instr, word, mode, rd_addr, sel, src} = 0;
		{errors, n_compared, cyc} = 0;
		i_sys_rst = 1'b1;
		seed = 16'hABB6;
		a = 10'h100;
		dst = 5'h1E;
		repeat (4) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		@(negedge i_clk) chk({o_instr_ready, o_data_ready, o_busy, o_done, o_illegal}, 5'h10);
		run(4'h6, 16'h1F00, 2'h0, 0, 2'h1);
		run(4'h5, 16'h1F00, 2'h0, 0, 2'h1);
		sel = 3'h1;
		run(4'h6, 16'h5F00, 2'h0, 0, 2'h0);
		sel = 3'h0;
		for (i = 0; i < 40; i = i + 1) begin
			seed = lfsr(seed);
			k[15:0] = seed;
			seed = lfsr(seed);
			k[31:16] = seed;
			seed = lfsr(seed);
			src = seed[3:0];
			dst = {2'b10, seed[6:4]};
			slow = seed[7];
			f = i2s(k);
			run(4'h6, 16'h5F00, 2'h0, k, 2'h2);
			rd(dst, i2s(k));
			rd({1'b0, src}, {32'h0, k});
			run(4'h6, 16'h1F80, 2'h0, 0, 2'h2);
			rd(dst, i2d(k));
			run(4'h6, 16'h1F00, 2'h0, 0, 2'h2);
			rd(dst, i2s(k));
			run(4'h6, 16'h5F80, 2'h0, k, 2'h2);
			rd(dst, i2d(k));
			if (i[0])
				a = a - 10'h020;
			host_model_inst.mem[a[9:5]] = f;
			run(4'h5, 16'h9F00, i[0] ? 2'h2 : 2'h1, 0, 2'h2);
			if (!i[0])
				a = a + 10'h020;
			rd(dst, f2i(f));
			rd({1'b0, src}, {32'h0, f});
			f = i == 0 ? 32'h7FC00000 : i == 1 ? 32'h4F000000 : i == 2 ? 32'hBF800000 : f;
			run(4'h5, 16'h5F00, 2'h0, f, 2'h2);
			rd(dst, f2i(f));
			// Memory form of integer to single
			host_model_inst.mem[a[9:5]] = k;
			run(4'h6, 16'h9F00, 2'h1, 0, 2'h2);
			a = a + 10'h020;
			rd(dst, i2s(k));
		end
		chk(host_model_inst.addr_reg, a);
		summarize;
	end
endmodule // float_int_convert_ops_tb

/* File: bench/host_model.sv */
// Host model offering operand words from a register or memory.
// Assumes the decoder takes a word on valid and ready.
`timescale 1ns/100ps
module host_model (
	// Control
	input wire i_clk,
	input wire [1:0] i_mode,
	input wire [31:0] i_word,
	input wire i_slow,
	// Operand handshake
	input wire i_ready,
	output reg o_valid,
	output reg [31:0] o_data
);
	reg [31:0] mem [0:31];
	reg [9:0] addr_reg = 10'h100;
	reg gap_reg = 1'b0;
	wire [9:0] pre = addr_reg - 10'h020;
	wire [31:0] word = i_mode == 2'h0 ? i_word : mem[i_mode[1] ? pre[9:5] : addr_reg[9:5]];
	initial o_valid = 1'b0;
	initial o_data = 32'h0;
	always @(posedge i_clk) begin
		gap_reg <= ~gap_reg;
		if (o_valid && i_ready) begin
			o_valid <= 1'b0;
			o_data <= ~o_data;
			if (i_mode[1])
				addr_reg <= pre;
			else if (i_mode[0])
				addr_reg <= addr_reg + 10'h020;
		end else if (i_ready && !o_valid && (!i_slow || gap_reg)) begin
			o_valid <= 1'b1;
			o_data <= word;
		end else if (!o_valid)
			o_data <= ~o_data;
	end
endmodule // host_model

/* File: core/fic_regs.vh */
// Constants for the float/integer conversion decoder.
// Assumes inclusion by the decoder and its converter only.
`ifndef FIC_REGS_VH
`define FIC_REGS_VH

// ----------------------------------------
// Instruction word fields
// ----------------------------------------
`define FIC_SEL_HI 31
`define FIC_SEL_LO 29
`define FIC_SRC_HI 28
`define FIC_SRC_LO 25
`define FIC_OPC_HI 24
`define FIC_OPC_LO 21
`define FIC_DST_HI 20
`define FIC_DST_LO 16
`define FIC_SUB_HI 15
`define FIC_SUB_LO 0

// ----------------------------------------
// Opcode and sub-code values
// ----------------------------------------
`define FIC_OPC_SGL_TO_INT 4'h5
`define FIC_OPC_INT_TO_FLT 4'h6
`define FIC_SUB_SHORT_FLT 16'h1F00
`define FIC_SUB_SHORT_DBL 16'h1F80
`define FIC_SUB_HREG_FLT 16'h5F00
`define FIC_SUB_HREG_DBL 16'h5F80
`define FIC_SUB_HMEM 16'h9F00

// ----------------------------------------
// Special register codes and reset values
// ----------------------------------------
`define FIC_REG_C 5'h1E
`define FIC_REG_CT 5'h1F
`define FIC_COPROC_SEL_RST 3'h0

// ----------------------------------------
// Conversion kinds
// ----------------------------------------
`define FIC_CONV_F2I 2'h0
`define FIC_CONV_I2D 2'h1
`define FIC_CONV_I2F 2'h2

`endif

/* File: core/float_int_convert_ops.v */
// Decoder and executor for the float/integer conversion instructions.
// Assumes the host logic runs on i_clk and offers one word per handshake.
`timescale 1ns/100ps
`include "fic_regs.vh"

// Contract
// - An instruction word splits into select 31:29, source 28:25, opcode 24:21, destination 20:16 and sub-code 15:0.
// - The host-register single-to-integer form latches the host word into the source and writes its integer to the destination.
// - The memory single-to-integer forms latch the memory word into the source and write its integer to the destination.
// - Short integer-to-double reads the source integer and writes its double to the destination.
// - Host-register integer-to-double loads the integer from a two-word move, converts and stores it.
// - Short integer-to-single reads the source integer and writes its single to the destination.
module float_int_convert_ops #(
	parameter [2:0] COPROC_SEL = `FIC_COPROC_SEL_RST
) (
	// Clock and reset
	input wire i_clk,
	input wire i_sys_rst,
	// Instruction words from the host
	input wire i_instr_valid,
	input wire [31:0] i_instr,
	output wire o_instr_ready,
	// Operand words from the host
	input wire i_data_valid,
	input wire [31:0] i_data,
	output wire o_data_ready,
	// Register file read port
	input wire [4:0] i_rd_addr,
	output reg [63:0] o_rd_data,
	// Status
	output reg o_busy,
	output reg o_done,
	output reg o_illegal
);

// ----------------------------------------
// States
// ----------------------------------------
localparam [3:0] ST_IDLE = 4'b0001;
localparam [3:0] ST_LOAD = 4'b0010;
localparam [3:0] ST_EXEC = 4'b0100;
localparam [3:0] ST_WRITE = 4'b1000;

reg [3:0] state_reg;
reg [3:0] state_next;
reg [1:0] kind_reg;
reg [3:0] src_reg;
reg [4:0] dst_reg;
reg [1:0] words_reg;
reg [63:0] result_reg;
reg [63:0] rf [0:31];

wire [63:0] conv_result;
wire [2:0] f_sel;
wire [3:0] f_src;
wire [3:0] f_opc;
wire [4:0] f_dst;
wire [15:0] f_sub;
reg dec_ok;
reg [1:0] dec_kind;
reg [1:0] dec_words;

// ----------------------------------------
// Field split
// ----------------------------------------
// fixed field positions
assign f_sel = i_instr[`FIC_SEL_HI:`FIC_SEL_LO];
assign f_src = i_instr[`FIC_SRC_HI:`FIC_SRC_LO];
assign f_opc = i_instr[`FIC_OPC_HI:`FIC_OPC_LO];
assign f_dst = i_instr[`FIC_DST_HI:`FIC_DST_LO];
assign f_sub = i_instr[`FIC_SUB_HI:`FIC_SUB_LO];

// ----------------------------------------
// Decode
// ----------------------------------------
// opcode plus sub-code pick kind and source
always @* begin
	dec_ok = 1'b0;
	dec_kind = `FIC_CONV_F2I;
	dec_words = 2'd0;
	if (f_opc == `FIC_OPC_SGL_TO_INT) begin
		dec_kind = `FIC_CONV_F2I;
		// memory forms look like a one-word host move
		if (f_sub == `FIC_SUB_HREG_FLT || f_sub == `FIC_SUB_HMEM) begin
			dec_ok = 1'b1;
			dec_words = 2'd1;
		end
	end else if (f_opc == `FIC_OPC_INT_TO_FLT) begin
		case (f_sub)
			`FIC_SUB_SHORT_DBL: begin
				dec_ok = 1'b1;
				dec_kind = `FIC_CONV_I2D;
			end
			`FIC_SUB_HREG_DBL: begin
				dec_ok = 1'b1;
				dec_kind = `FIC_CONV_I2D;
				dec_words = 2'd2;
			end
			`FIC_SUB_SHORT_FLT: begin
				dec_ok = 1'b1;
				dec_kind = `FIC_CONV_I2F;
			end
			`FIC_SUB_HREG_FLT, `FIC_SUB_HMEM: begin
				dec_ok = 1'b1;
				dec_kind = `FIC_CONV_I2F;
				dec_words = 2'd1;
			end
			default: begin
				dec_ok = 1'b0;
			end
		endcase
	end
	// refuse C and count/temporary in the short forms
	if (dec_ok && dec_words == 2'd0 && (f_dst == `FIC_REG_C || f_dst == `FIC_REG_CT))
		dec_ok = 1'b0;
end

assign o_instr_ready = (state_reg == ST_IDLE);
assign o_data_ready = (state_reg == ST_LOAD);

// ----------------------------------------
// Sequencer
// ----------------------------------------
always @* begin
	state_next = state_reg;
	case (state_reg)
		ST_IDLE: begin
			// Other select codes belong to another coprocessor
			if (i_instr_valid && f_sel == COPROC_SEL && dec_ok)
				state_next = (dec_words == 2'd0) ? ST_EXEC : ST_LOAD;
		end
		ST_LOAD: begin
			if (i_data_valid && words_reg == 2'd1)
				state_next = ST_EXEC;
		end
		ST_EXEC: begin
			state_next = ST_WRITE;
		end
		ST_WRITE: begin
			state_next = ST_IDLE;
		end
		default: begin
			state_next = ST_IDLE;
		end
	endcase
end

always @(posedge i_clk or posedge i_sys_rst) begin
	if (i_sys_rst) begin
		state_reg <= ST_IDLE;
		kind_reg <= 2'h0;
		src_reg <= 4'h0;
		dst_reg <= 5'h0;
		words_reg <= 2'h0;
		result_reg <= 64'h0;
		o_rd_data <= 64'h0;
		o_busy <= 1'b0;
		o_done <= 1'b0;
		o_illegal <= 1'b0;
	end else begin
		state_reg <= state_next;
		o_rd_data <= rf[i_rd_addr];
		o_busy <= (state_next != ST_IDLE);
		o_done <= (state_reg == ST_WRITE);
		o_illegal <= (state_reg == ST_IDLE) && i_instr_valid && f_sel == COPROC_SEL && !dec_ok;
		if (state_reg == ST_IDLE && i_instr_valid) begin
			kind_reg <= dec_kind;
			// source index lives in the first half of the file
			src_reg <= f_src;
			dst_reg <= f_dst;
			words_reg <= dec_words;
		end
		if (state_reg == ST_LOAD && i_data_valid)
			words_reg <= words_reg - 2'd1;
		if (state_reg == ST_EXEC)
			result_reg <= conv_result;
	end
end

// ----------------------------------------
// Register file
// ----------------------------------------
// No reset: contents are data, not control
always @(posedge i_clk) begin
	// host word lands in the source register
	// second word repeats the first, so either one serves
	if (state_reg == ST_LOAD && i_data_valid)
		rf[{1'b0, src_reg}] <= {32'h0, i_data};
	if (state_reg == ST_WRITE)
		rf[dst_reg] <= result_reg;
end

fp_convert_unit fp_convert_unit_inst (
	.i_kind(kind_reg),
	.i_operand(rf[{1'b0, src_reg}][31:0]),
	.o_result(conv_result)
);

endmodule // float_int_convert_ops

/* File: core/fp_convert_unit.v */
// Combinational float/integer converter.
// Assumes the caller registers the result.
`timescale 1ns/100ps
`include "fic_regs.vh"

module fp_convert_unit (
	// Request
	input wire [1:0] i_kind,
	input wire [31:0] i_operand,
	// Result
	output reg [63:0] o_result
);

reg sign;
reg [31:0] mag;
reg [31:0] norm;
reg [5:0] lz;
reg found;
reg rnd;
reg [30:0] sgl_bits;
reg [7:0] exp8;
reg [10:0] exp11;
reg [31:0] shifted;
reg [7:0] shamt;
integer k;

always @* begin
	sign = i_operand[31];
	mag = sign ? (32'h0 - i_operand) : i_operand;
	lz = 6'h0;
	found = 1'b0;
	for (k = 31; k >= 0; k = k - 1) begin
		if (!found && mag[k]) begin
			found = 1'b1;
			lz = 6'd31 - k[5:0];
		end
	end
	norm = mag << lz;
	exp8 = 8'd158 - {2'h0, lz};
	exp11 = 11'd1054 - {5'h0, lz};
	// Nearest even; a carry out of the mantissa bumps the exponent
	rnd = norm[7] & ((|norm[6:0]) | norm[8]);
	sgl_bits = {exp8, norm[30:8]} + {30'h0, rnd};
	shamt = 8'd158 - i_operand[30:23];
	shifted = {1'b1, i_operand[22:0], 8'h00} >> shamt[4:0];
	o_result = 64'h0;
	case (i_kind)
		`FIC_CONV_F2I: begin
			if (i_operand[30:23] < 8'd127) begin
				o_result = 64'h0;
			end else if (i_operand[30:23] >= 8'd158) begin
				// Out of range saturates; NaN goes positive
				if (sign && !(i_operand[30:23] == 8'hFF && |i_operand[22:0]))
					o_result = {32'h0, 32'h80000000};
				else
					o_result = {32'h0, 32'h7FFFFFFF};
			end else begin
				o_result = {32'h0, sign ? (32'h0 - shifted) : shifted};
			end
		end
		`FIC_CONV_I2D: begin
			if (found)
				o_result = {sign, exp11, norm[30:0], 21'h0};
		end
		`FIC_CONV_I2F: begin
			if (found)
				o_result = {32'h0, sign, sgl_bits};
		end
		default: begin
			o_result = 64'h0;
		end
	endcase
end

endmodule // fp_convert_unit
